// ==== rtl/lxr_defs.vh ====
// Register offsets, field positions, reset values and timing counts
`ifndef LXR_DEFS_VH
`define LXR_DEFS_VH
`define LXR_ADDR_HPOS        8'h02
`define LXR_ADDR_TEXTPOS     8'h03
`define LXR_ADDR_ACTIVITY    8'h04
`define LXR_ADDR_FILTER      8'h05
`define LXR_ADDR_IRQ_REQ     8'h06
`define LXR_ADDR_IRQ_MASK    8'h07
`define LXR_ADDR_STATION_INFO_CLASS_SELECT_ACT    8'h08
`define LXR_RST_HPOS         8'h26
`define LXR_RST_TEXTPOS      8'hff
`define LXR_RST_FILTER       8'h00
`define LXR_RST_MASK         8'h00
`define LXR_BIT_POLARITY     6
`define LXR_BIT_BOXCOL       7
`define LXR_BIT_DLE          1
`define LXR_BIT_EOF          2
`define LXR_BIT_LOCK         3
`define LXR_BIT_SCH          4
`define LXR_BIT_XDS          5
`define LXR_BIT_CAP          6
`define LXR_BIT_TXT          7
`define LXR_SEC_ALL          3'h0
`define LXR_SEC_TIME         3'h1
`define LXR_SEC_INBAND       3'h2
`define LXR_SEC_RATING       3'h3
`define LXR_SEC_VCR          3'h4
`define LXR_HSTEP_NS         330
`define LXR_CLK_NS           50
`define LXR_TIMEOUT_S        16
`define LXR_STATION_INFO_CLASS_SELECT_TIMEOUT_S   12
`define LXR_CLK_HZ           20000000
`endif

// ==== rtl/lxr_activity_timer.v ====
// Retriggerable activity timer: set by a hit, cleared after a quiet period
`timescale 1ns/1ps
`include "lxr_defs.vh"
module lxr_activity_timer #(
  parameter CYCLES = 64'd320000000,
  parameter CW     = 29
) (
  // Clock and reset
  input  wire core_clk_i,
  input  wire rst_n_i,
  // Activity events
  input  wire hit_i,
  input  wire kill_i,
  // Status
  output reg  active_o
);
  reg [CW-1:0] count;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count    <= {CW{1'b0}};
      active_o <= 1'b0;
    end else if (kill_i) begin
      count    <= {CW{1'b0}};
      active_o <= 1'b0;
    end else if (hit_i) begin
      count    <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      active_o <= 1'b1;
    end else if (count != {CW{1'b0}}) begin
      count <= count - {{(CW-1){1'b0}}, 1'b1};
    end else begin
      active_o <= 1'b0;
    end
  end
endmodule

// ==== rtl/lxr_regs.v ====
// Register bank for display position, Packet_class_filter, activity and interrupt requests
`timescale 1ns/1ps
`include "lxr_defs.vh"
module lxr_regs #(
  parameter SEL_TIMEOUT  = 64'd320000000,
  parameter STATION_INFO_CLASS_SELECT_TIMEOUT = 64'd240000000
) (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  // Register access from serial control port
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  output reg  [7:0] reg_rdata_o,
  // Video and decoder events
  input  wire       sync_locked_i,
  input  wire       data_line_end_i,
  input  wire       field_end_i,
  input  wire       row15_clear_i,
  input  wire       sel_station_info_class_select_data_i,
  input  wire       xds_data_i,
  input  wire [7:0] mode_cmd_hit_i,
  // XDS packet to qualify
  input  wire       xds_pkt_valid_i,
  input  wire [3:0] xds_pkt_class_i,
  input  wire [6:0] xds_pkt_type_i,
  output reg        xds_pkt_pass_o,
  // Display controls
  output wire [5:0] horiz_position_o,
  output wire       lock_edge_polarity_o,
  output wire       box_colour_select_o,
  output reg  [3:0] text_first_row_o,
  output wire [3:0] text_row_count_o,
  output wire       xds_recovery_en_o,
  // Status
  output wire       selected_channel_active_o,
  output wire       xds_active_o,
  output wire [7:0] channel_activity_o,
  output wire       irq_o
);
  // Timer widths sized for the documented default counts
  localparam TW = 29;

  reg  [7:0] horizontal_position;
  reg  [7:0] text_window_position;
  reg  [7:0] packet_class_filter;
  reg  [7:0] interrupt_request_flags;
  reg  [7:0] interrupt_mask;
  reg        lock_prev;
  reg        sch_prev;
  reg        xds_prev;
  reg  [7:0] station_info_class_select_prev;
  reg  [7:0] next_req;
  reg  [4:0] first_row_calc;
  wire       sel_act;
  wire       xds_act;
  wire [7:0] station_info_class_select_act;
  wire       lock_lost;
  wire       wr_req;
  wire [7:0] set_ev;

  // Class bit from XDS class code (start codes 1,3,5,7,9 and continue codes 2,4,6,8,10)
  function [4:0] class_onehot;
    input [3:0] cls;
    begin
      case (cls)
        4'h1, 4'h2: class_onehot = 5'h01;
        4'h3, 4'h4: class_onehot = 5'h02;
        4'h5, 4'h6: class_onehot = 5'h04;
        4'h7, 4'h8: class_onehot = 5'h08;
        4'h9, 4'ha: class_onehot = 5'h10;
        default:    class_onehot = 5'h00;
      endcase
    end
  endfunction

  // Register writes
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      horizontal_position  <= `LXR_RST_HPOS;
      text_window_position <= `LXR_RST_TEXTPOS;
      packet_class_filter  <= `LXR_RST_FILTER;
      interrupt_mask       <= `LXR_RST_MASK;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `LXR_ADDR_HPOS:     horizontal_position  <= reg_wdata_i;
        `LXR_ADDR_TEXTPOS:  text_window_position <= reg_wdata_i;
        `LXR_ADDR_FILTER:   packet_class_filter  <= reg_wdata_i;
        `LXR_ADDR_IRQ_MASK: interrupt_mask       <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Display fields; each step of position is one 330 ns pixel-timing unit
  assign horiz_position_o     = horizontal_position[5:0];
  assign lock_edge_polarity_o = horizontal_position[`LXR_BIT_POLARITY];
  assign box_colour_select_o  = horizontal_position[`LXR_BIT_BOXCOL];
  assign text_row_count_o     = text_window_position[3:0];

  // First row = base - count + 1, clamped to row 1 when above the screen
  always @* begin
    first_row_calc = {1'b0, text_window_position[7:4]} + 5'd1
                     - {1'b0, text_window_position[3:0]};
    if (first_row_calc[4] || first_row_calc == 5'd0) begin
      text_first_row_o = 4'h1;
    end else begin
      text_first_row_o = first_row_calc[3:0];
    end
  end

  // Activity timers; restarting on each hit keeps the bit high while data flows
  assign lock_lost = lock_prev & ~sync_locked_i;

  lxr_activity_timer #(.CYCLES(SEL_TIMEOUT), .CW(TW)) u_sel_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .hit_i      (sel_station_info_class_select_data_i),
    .kill_i     (1'b0),
    .active_o   (sel_act)
  );

  lxr_activity_timer #(.CYCLES(SEL_TIMEOUT), .CW(TW)) u_xds_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .hit_i      (xds_data_i),
    .kill_i     (1'b0),
    .active_o   (xds_act)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_station_info_class_select
      lxr_activity_timer #(.CYCLES(STATION_INFO_CLASS_SELECT_TIMEOUT), .CW(TW)) u_station_info_class_select_timer (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .hit_i      (mode_cmd_hit_i[g]),
        .kill_i     (lock_lost),
        .active_o   (station_info_class_select_act[g])
      );
    end
  endgenerate

  assign selected_channel_active_o = sel_act;
  assign xds_active_o              = xds_act;
  assign channel_activity_o        = station_info_class_select_act;

  // Previous values for change detection
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_prev <= 1'b0;
      sch_prev  <= 1'b0;
      xds_prev  <= 1'b0;
      station_info_class_select_prev <= 8'h00;
    end else begin
      lock_prev <= sync_locked_i;
      sch_prev  <= sel_act;
      xds_prev  <= xds_act;
      station_info_class_select_prev <= station_info_class_select_act;
    end
  end

  // Events per request bit; bit 0 is reserved and never sets
  assign set_ev[0] = 1'b0;
  assign set_ev[`LXR_BIT_DLE]  = data_line_end_i;
  assign set_ev[`LXR_BIT_EOF]  = field_end_i;
  assign set_ev[`LXR_BIT_LOCK] = lock_prev ^ sync_locked_i;
  assign set_ev[`LXR_BIT_SCH]  = sch_prev ^ sel_act;
  assign set_ev[`LXR_BIT_XDS]  = xds_prev ^ xds_act;
  assign set_ev[`LXR_BIT_CAP]  = |(station_info_class_select_prev[3:0] ^ station_info_class_select_act[3:0]);
  assign set_ev[`LXR_BIT_TXT]  = |(station_info_class_select_prev[7:4] ^ station_info_class_select_act[7:4]);

  assign wr_req = reg_wr_i && (reg_addr_i == `LXR_ADDR_IRQ_REQ);

  // Set wins over any clear in the same cycle
  always @* begin
    next_req = interrupt_request_flags;
    if (wr_req) begin
      next_req = next_req & ~{reg_wdata_i[7:3], 3'b000};
    end
    if (row15_clear_i) begin
      next_req[`LXR_BIT_DLE] = 1'b0;
      next_req[`LXR_BIT_EOF] = 1'b0;
    end
    next_req = next_req | set_ev;
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interrupt_request_flags <= 8'h00;
    end else begin
      interrupt_request_flags <= next_req;
    end
  end

  assign irq_o = |(interrupt_request_flags & interrupt_mask);

  // Packet_class_filter qualification
  assign xds_recovery_en_o = |packet_class_filter[4:0];

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xds_pkt_pass_o <= 1'b0;
    end else begin
      xds_pkt_pass_o <= 1'b0;
      if (xds_pkt_valid_i && xds_recovery_en_o) begin
        if (&packet_class_filter[4:0]
            && packet_class_filter[7:5] == `LXR_SEC_ALL) begin
          xds_pkt_pass_o <= 1'b1;
        end else if (|(class_onehot(xds_pkt_class_i) & packet_class_filter[4:0])) begin
          case (packet_class_filter[7:5])
            `LXR_SEC_ALL:    xds_pkt_pass_o <= 1'b1;
            `LXR_SEC_TIME:   xds_pkt_pass_o <= xds_pkt_class_i[3:1] == 3'h3
                                && (xds_pkt_type_i == 7'h01 || xds_pkt_type_i == 7'h04);
            `LXR_SEC_INBAND: xds_pkt_pass_o <= xds_pkt_class_i[3:1] != 3'h2;
            `LXR_SEC_RATING: xds_pkt_pass_o <= xds_pkt_class_i[3:1] == 3'h0
                                && xds_pkt_type_i == 7'h05;
            `LXR_SEC_VCR: begin
              case ({xds_pkt_class_i[3:1], xds_pkt_type_i})
                {3'h3, 7'h01}, {3'h3, 7'h04}, {3'h2, 7'h01}, {3'h2, 7'h02},
                {3'h3, 7'h02}, {3'h2, 7'h04}, {3'h0, 7'h0d}, {3'h2, 7'h03}: begin
                  xds_pkt_pass_o <= 1'b1;
                end
                default: xds_pkt_pass_o <= 1'b0;
              endcase
            end
            default: xds_pkt_pass_o <= 1'b0;
          endcase
        end
      end
    end
  end

  // Read data registered; unmapped and reserved bits read zero
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `LXR_ADDR_HPOS:     reg_rdata_o <= horizontal_position;
        `LXR_ADDR_TEXTPOS:  reg_rdata_o <= text_window_position;
        `LXR_ADDR_ACTIVITY: reg_rdata_o <= {6'h00, xds_act, sel_act};
        `LXR_ADDR_FILTER:   reg_rdata_o <= packet_class_filter;
        `LXR_ADDR_IRQ_REQ:  reg_rdata_o <= interrupt_request_flags;
        `LXR_ADDR_IRQ_MASK: reg_rdata_o <= interrupt_mask;
        `LXR_ADDR_STATION_INFO_CLASS_SELECT_ACT: reg_rdata_o <= station_info_class_select_act;
        default:            reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// ==== bench/lxr_asserts.sv ====
// Port checker for the register bank
`timescale 1ns/1ps
module lxr_asserts (
  // Clock and reset
  input wire       core_clk_i,
  input wire       rst_n_i,
  // Register port and events
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       sync_locked_i,
  input wire       sel_station_info_class_select_data_i,
  input wire       xds_data_i,
  // Design outputs
  input wire [5:0] horiz_position_o,
  input wire       lock_edge_polarity_o,
  input wire       box_colour_select_o,
  input wire [3:0] text_first_row_o,
  input wire [3:0] text_row_count_o,
  input wire       xds_recovery_en_o,
  input wire       selected_channel_active_o,
  input wire       xds_active_o,
  input wire [7:0] channel_activity_o,
  input wire       irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire w2 = reg_wr_i && reg_addr_i == 8'h02;
  wire w3 = reg_wr_i && reg_addr_i == 8'h03;
  wire w5 = reg_wr_i && reg_addr_i == 8'h05;
  wire w7 = reg_wr_i && reg_addr_i == 8'h07;
  property p_hpos;
    w2 |=> {box_colour_select_o, lock_edge_polarity_o, horiz_position_o} == $past(reg_wdata_i);
  endproperty
  a_hpos: assert property (p_hpos) else $error("hpos");
  property p_tcnt; w3 |=> text_row_count_o == $past(reg_wdata_i[3:0]); endproperty
  a_tcnt: assert property (p_tcnt) else $error("rows");
  // Window running off the top is pinned to row 1
  property p_top; w3 && reg_wdata_i[7:4] < reg_wdata_i[3:0] |=> text_first_row_o == 4'h1;
  endproperty
  a_top: assert property (p_top) else $error("top");
  property p_sel; sel_station_info_class_select_data_i |=> selected_channel_active_o; endproperty
  a_sel: assert property (p_sel) else $error("sel");
  property p_xds; xds_data_i |=> xds_active_o; endproperty
  a_xds: assert property (p_xds) else $error("xds");
  property p_rec; w5 |=> xds_recovery_en_o == ($past(reg_wdata_i[4:0]) != 5'h00); endproperty
  a_rec: assert property (p_rec) else $error("rec");
  property p_lock; $fell(sync_locked_i) |=> channel_activity_o == 8'h00; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_mask; w7 && reg_wdata_i == 8'h00 |=> !irq_o; endproperty
  a_mask: assert property (p_mask) else $error("mask");
  c_irq: cover property (irq_o);
  c_fall: cover property ($fell(selected_channel_active_o));
  c_top: cover property (w3 && reg_wdata_i[7:4] < reg_wdata_i[3:0]);
endmodule
bind lxr_regs lxr_asserts u_chk (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .sync_locked_i, .sel_station_info_class_select_data_i, .xds_data_i, .horiz_position_o,
  .lock_edge_polarity_o, .box_colour_select_o, .text_first_row_o, .text_row_count_o,
  .xds_recovery_en_o, .selected_channel_active_o, .xds_active_o, .channel_activity_o,
  .irq_o);

// ==== bench/lxr_host_model.sv ====
// Host processor model on the register port
`timescale 1ns/1ps
module lxr_host_model (
  // Clock
  input  wire       core_clk_i,
  // Register port drive
  output reg  [7:0] reg_addr_o,
  output reg  [7:0] reg_wdata_o,
  output reg        reg_wr_o,
  output reg        rd_valid_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    rd_valid_o = 1'b0;
  end
  // Write one byte to a register with a one-cycle strobe
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
    end
  endtask
  // Read data is registered, so valid one cycle after the address
  task rd(input [7:0] a);
    begin
      @(posedge core_clk_i);
      reg_addr_o <= a;
      @(posedge core_clk_i);
      rd_valid_o <= 1'b1;
      @(posedge core_clk_i);
      rd_valid_o <= 1'b0;
    end
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i;
  logic       sync_locked_i;
  logic [4:0] ev;
  logic [7:0] mode_cmd_hit_i;
  logic       xds_pkt_valid_i;
  logic [3:0] xds_pkt_class_i;
  logic [6:0] xds_pkt_type_i;
  wire  [7:0] ha, hd, reg_rdata_o;
  wire        hw, hv, xds_pkt_pass_o, irq_o;
  wire  [3:0] text_first_row_o;
  logic [7:0] q[$];
  logic [7:0] r, h;
  integer     seed, err_total, n_checks, cyc;
  always #25 core_clk_i = ~core_clk_i;
  lxr_host_model u_host (.core_clk_i, .reg_addr_o(ha), .reg_wdata_o(hd), .reg_wr_o(hw),
    .rd_valid_o(hv));
  // Short timeouts keep the quiet-period checks fast
  lxr_regs #(.SEL_TIMEOUT(64'd20), .STATION_INFO_CLASS_SELECT_TIMEOUT(64'd20)) u_dut (.core_clk_i, .rst_n_i,
    .reg_addr_i(ha), .reg_wdata_i(hd), .reg_wr_i(hw), .reg_rdata_o, .sync_locked_i,
    .data_line_end_i(ev[0]), .field_end_i(ev[1]), .row15_clear_i(ev[2]),
    .sel_station_info_class_select_data_i(ev[3]), .xds_data_i(ev[4]), .mode_cmd_hit_i, .xds_pkt_valid_i,
    .xds_pkt_class_i, .xds_pkt_type_i, .xds_pkt_pass_o, .horiz_position_o(),
    .lock_edge_polarity_o(), .box_colour_select_o(), .text_first_row_o,
    .text_row_count_o(), .xds_recovery_en_o(), .selected_channel_active_o(),
    .xds_active_o(), .channel_activity_o(), .irq_o);
  task stop_test;
    begin
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [7:0] e, input [7:0] a);
    begin
      n_checks = n_checks + 1;
      if (e !== a) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
      end
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      q.push_back(e);
      u_host.rd(a);
    end
  endtask
  task pe(input [4:0] m);
    begin
      @(posedge core_clk_i);
      ev <= m;
      @(posedge core_clk_i);
      ev <= 5'h00;
      repeat (2) @(posedge core_clk_i);
    end
  endtask
  task pkt(input [3:0] c, input e);
    begin
      @(posedge core_clk_i);
      xds_pkt_valid_i <= 1'b1;
      xds_pkt_class_i <= c;
      xds_pkt_type_i <= 7'($random(seed));
      @(posedge core_clk_i);
      xds_pkt_valid_i <= 1'b0;
      @(negedge core_clk_i);
      chk({7'h00, e}, {7'h00, xds_pkt_pass_o});
    end
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (hv === 1'b1)
      chk(q.pop_front(), reg_rdata_o);
    if (cyc == 4000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  initial begin
    seed = 32'h4ebbca90;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    sync_locked_i = 1'b0;
    ev = 5'h00;
    mode_cmd_hit_i = 8'h00;
    xds_pkt_valid_i = 1'b0;
    xds_pkt_class_i = 4'h0;
    xds_pkt_type_i = 7'h00;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rdc(8'h02, 8'h26);
    rdc(8'h03, 8'hff);
    rdc(8'h09, 8'h00);
    r = 8'($random(seed));
    u_host.wr(8'h02, r);
    rdc(8'h02, r);
    u_host.wr(8'h03, 8'hc8);
    @(negedge core_clk_i);
    chk(8'h05, {4'h0, text_first_row_o});
    u_host.wr(8'h03, 8'h3a);
    @(negedge core_clk_i);
    chk(8'h01, {4'h0, text_first_row_o});
    u_host.wr(8'h08, 8'hff);
    rdc(8'h08, 8'h00);
    @(posedge core_clk_i);
    sync_locked_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rdc(8'h06, 8'h08);
    u_host.wr(8'h06, 8'hf7);
    rdc(8'h06, 8'h08);
    u_host.wr(8'h07, 8'hff);
    @(negedge core_clk_i);
    chk(8'h01, {7'h00, irq_o});
    u_host.wr(8'h06, 8'h08);
    @(negedge core_clk_i);
    chk(8'h00, {7'h00, irq_o});
    pe(5'h18);
    rdc(8'h04, 8'h03);
    rdc(8'h06, 8'h30);
    u_host.wr(8'h07, 8'h00);
    @(negedge core_clk_i);
    chk(8'h00, {7'h00, irq_o});
    u_host.wr(8'h06, 8'h30);
    repeat (30) @(posedge core_clk_i);
    rdc(8'h04, 8'h00);
    rdc(8'h06, 8'h30);
    u_host.wr(8'h06, 8'hff);
    h = 8'($random(seed)) | 8'h11;
    @(posedge core_clk_i);
    mode_cmd_hit_i <= h;
    @(posedge core_clk_i);
    mode_cmd_hit_i <= 8'h00;
    repeat (2) @(posedge core_clk_i);
    rdc(8'h08, h);
    rdc(8'h06, 8'hc0);
    @(posedge core_clk_i);
    sync_locked_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rdc(8'h08, 8'h00);
    rdc(8'h06, 8'hc8);
    pe(5'h03);
    u_host.wr(8'h06, 8'hff);
    rdc(8'h06, 8'h06);
    pe(5'h04);
    rdc(8'h06, 8'h00);
    u_host.wr(8'h05, 8'h1f);
    for (int k = 0; k < 16; k++)
      pkt(k[3:0], 1'b1);
    u_host.wr(8'h05, 8'h00);
    pkt(4'h1, 1'b0);
    u_host.wr(8'h05, 8'h01);
    pkt(4'h1, 1'b1);
    pkt(4'h3, 1'b0);
    u_host.wr(8'h05, 8'he1);
    pkt(4'h1, 1'b0);
    stop_test;
  end
endmodule
